// ---- hw/bss_pkg.sv ----
// Shared constants, register layouts and types of the start-up sequencer
`default_nettype none
package bss_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TICK_NS = 1000; // Time base of align and open loop
  localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ALIGN = 8'h04;
  localparam logic [7:0] OFF_CAPS = 8'h08;
  localparam logic [7:0] OFF_OPEN = 8'h0C;
  localparam logic [7:0] OFF_ACCEL = 8'h10;
  localparam logic [7:0] OFF_HAND = 8'h14;
  localparam logic [7:0] OFF_SENSE = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [24:0] rsv;
    logic halt;
    logic dir_rev;
    logic auto_hand;
    logic release_sel;
    logic cap_src;
    logic [1:0] method;
  } bss_ctrl_t;
  typedef struct packed {
    logic [7:0] ramp_step;
    logic [7:0] duty;
    logic [15:0] time_ticks;
  } bss_align_t;
  typedef struct packed {
    logic [7:0] rsv;
    logic [7:0] sense_thr;
    logic [7:0] ol_cap;
    logic [7:0] gen_cap;
  } bss_caps_t;
  typedef struct packed {
    logic [5:0] rsv;
    logic [1:0] advance;
    logic [15:0] first_period;
    logic [7:0] duty;
  } bss_open_t;
  typedef struct packed {
    logic [15:0] a2;
    logic [15:0] a1;
  } bss_accel_t;
  typedef struct packed {
    logic [15:0] rsv;
    logic [15:0] limit;
  } bss_word_t;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ALIGN_RST = 32'h0180_03E8;
  localparam logic [31:0] CAPS_RST = 32'h0040_8080;
  localparam logic [31:0] OPEN_RST = 32'h0003_E840;
  localparam logic [31:0] ACCEL_RST = 32'h0001_0010;
  localparam logic [31:0] HAND_RST = 32'h0000_0100;
  localparam logic [31:0] SENSE_RST = 32'h0000_0400;
  localparam logic [1:0] M_ALIGN = 2'h0;
  localparam logic [1:0] M_DOUBLE = 2'h1;
  localparam logic [1:0] M_SENSE = 2'h2;
  localparam logic [1:0] M_SLOW = 2'h3;
  localparam logic [2:0] SEC_LAST = 3'h5;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] hi; // Bit 0 is phase A
    logic [2:0] lo;
  } bss_gate_t;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ALIGN = 8'h02,
    ST_SDRIVE = 8'h04,
    ST_SREL = 8'h08,
    ST_PICK = 8'h10,
    ST_OPEN = 8'h20,
    ST_CLOSED = 8'h40,
    ST_SPARE = 8'h80
  } bss_state_t;
endpackage
`default_nettype wire

// ---- hw/bss_tmem.sv ----
// Small memory holding the six sensing rise times
`default_nettype none
module bss_tmem #(
  parameter int W = 16,
  parameter int D = 6
) (
  input wire logic core_clk, // Clock
  input wire logic clk_en, // Freeze when low
  input wire logic we, // Write strobe
  input wire logic [2:0] waddr, // Write index
  input wire logic [W-1:0] wdata, // Write data
  input wire logic [2:0] raddr, // Read index
  output logic [W-1:0] rdata_q // Registered read data
);
  logic [W-1:0] mem [D];
  always_ff @(posedge core_clk)
  begin
    if (clk_en)
    begin
      if (we)
        mem[waddr] <= wdata;
      rdata_q <= (int'(raddr) < D) ? mem[raddr] : '0;
    end
  end
endmodule // bss_tmem
`default_nettype wire

// ---- hw/bss_accel.sv ----
// Open-loop speed generator, second order in time
`default_nettype none
module bss_accel #(
  parameter int W = 24
) (
  input wire logic core_clk, // Clock
  input wire logic reset, // Sync reset, active high
  input wire logic clk_en, // Freeze when low
  input wire logic clear, // Restart from zero speed
  input wire logic step, // One time step
  input wire logic [15:0] a1, // Linear coefficient
  input wire logic [15:0] a2, // Quadratic coefficient
  output logic [W-1:0] speed_q // Current speed
);
  import bss_pkg::*;
  logic [W-1:0] accel_q, accel_d, speed_d;
  logic [W:0] acc_sum;
  logic [W+1:0] spd_sum;
  // Speed(n) = a1*n + a2*n*(n-1)/2, the discrete form of a1*t+a2*t*t/2
  always_comb
  begin
    acc_sum = {1'b0, accel_q} + {{(W-15){1'b0}}, a2};
    spd_sum = {2'b00, speed_q} + {{(W-14){1'b0}}, a1} + {2'b00, accel_q};
    accel_d = accel_q;
    speed_d = speed_q;
    if (clear)
    begin
      accel_d = '0;
      speed_d = '0;
    end
    else if (step)
    begin
      // Saturate rather than wrap to a slow speed
      accel_d = acc_sum[W] ? '1 : acc_sum[W-1:0];
      speed_d = (spd_sum[W+1:W] != 2'b00) ? '1 : spd_sum[W-1:0];
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      accel_q <= '0;
      speed_q <= '0;
    end
    else if (clk_en)
    begin
      accel_q <= accel_d;
      speed_q <= speed_d;
    end
  end
endmodule // bss_accel
`default_nettype wire

// ---- hw/bss_top.sv ----
// Start-up sequencer for a sensorless trapezoidal BLDC driver
// ------------------------------------------------------------------
// Behaviour
// - Method 00 aligns with phase C high and B low for align time.
// - Align duty ramps up from zero to align duty at ramp rate.
// - Align current cap is general or open-loop cap by source select.
// - Method 01 adds a second align one sector ahead in direction.
// - Both aligns use same time, cap and ramp rate, one after other.
// - Method 10 senses position by inductance instead of aligning.
// - Sensing applies six patterns in order BC, CB, BA, CA, AC, AB.
// - Each pattern stops at current threshold; elapsed time is stored.
// - Shortest rise time marks the north-pole aligned sector.
// - Release select 0 keeps the low switch on to recirculate.
// - Release select 1 turns both switches off at release.
// - Open loop starts at detected sector plus advance.
// - Method 11 runs the first cycle at fixed rate, then accelerates.
// - Open loop uses fixed duty and a cycle-by-cycle current cap.
// - Open-loop cap is general or open-loop cap by source select.
// - Open-loop speed follows a1*t plus a2*t*t/2 from configuration.
// - Auto handover picks speed itself, else uses speed threshold.
// - Closed loop commutates on back-EMF zero crossing.
// - Closed-loop duty equals the speed path duty value.
// - Start-up begins once the brake checks are done or skipped.
// - Reverse direction uses the same handover, accel and cap values.
// ------------------------------------------------------------------
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`default_nettype none
module bss_top #(
  parameter int SPEED_W = 24,
  parameter logic [23:0] AUTO_SPEED = 24'h00_4000
) (
  input wire logic core_clk, // 100 MHz clock
  input wire logic reset, // Sync reset, active high
  input wire logic clk_en, // Freezes all state when low
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, words only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire logic start_req, // Brake checks done or skipped
  input wire logic cur_at_thr, // Phase current at cur_thr_q
  input wire logic pwm_sync, // Start of each PWM period
  input wire logic zero_cross, // Zero crossing on floating phase
  input wire logic [7:0] duty_out, // Duty from speed path
  output bss_pkg::bss_gate_t gate_q, // Half-bridge switch commands
  output logic [7:0] duty_q, // Applied duty
  output logic [7:0] cur_thr_q // Current comparator level
);
  import bss_pkg::*;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic bss_gate_t pat(input logic [2:0] s);
    case (s)
      3'h0: pat = '{3'b100, 3'b010};
      3'h1: pat = '{3'b001, 3'b010};
      3'h2: pat = '{3'b001, 3'b100};
      3'h3: pat = '{3'b010, 3'b100};
      3'h4: pat = '{3'b010, 3'b001};
      3'h5: pat = '{3'b100, 3'b001};
      default: pat = '0;
    endcase
  endfunction
  function automatic logic [2:0] sec_step(input logic [2:0] s,
      input logic [1:0] n, input logic rev);
    logic [3:0] t;
    t = rev ? 4'(s) + 4'h6 - 4'(n) : 4'(s) + 4'(n);
    if (t >= 4'h6)
      t = t - 4'h6;
    return t[2:0];
  endfunction
  function automatic logic [2:0] sense_sec(input logic [2:0] i);
    case (i)
      3'h0: sense_sec = 3'h3;
      3'h1: sense_sec = 3'h0;
      3'h2: sense_sec = 3'h4;
      3'h3: sense_sec = 3'h5;
      3'h4: sense_sec = 3'h2;
      default: sense_sec = 3'h1;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  bss_ctrl_t ctrl_q, ctrl_d;
  bss_align_t align_q, align_d;
  bss_caps_t caps_q, caps_d;
  bss_open_t open_q, open_d;
  bss_accel_t accel_q, accel_d;
  bss_word_t hand_q, hand_d, sense_q, sense_d;
  logic wr_q, wr_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] rdata_d;
  logic take;
  bss_state_t st_q, st_d;
  logic [2:0] sec_q, sec_d, min_sec_q, min_sec_d;
  always_comb
  begin
    take = hsel & hready & htrans[1];
    wr_d = take & hwrite & (haddr[31:8] == 24'h00_0000);
    addr_d = take ? haddr[7:0] : addr_q;
    rdata_d = 32'h0000_0000;
    if (take & ~hwrite & (haddr[31:8] == 24'h00_0000))
    begin
      case (haddr[7:0])
        OFF_CTRL: rdata_d = ctrl_q;
        OFF_ALIGN: rdata_d = align_q;
        OFF_CAPS: rdata_d = caps_q;
        OFF_OPEN: rdata_d = open_q;
        OFF_ACCEL: rdata_d = accel_q;
        OFF_HAND: rdata_d = hand_q;
        OFF_SENSE: rdata_d = sense_q;
        OFF_STATUS: rdata_d = {16'h0000, st_q, 2'b00, min_sec_q, sec_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    ctrl_d = ctrl_q;
    align_d = align_q;
    caps_d = caps_q;
    open_d = open_q;
    accel_d = accel_q;
    hand_d = hand_q;
    sense_d = sense_q;
    if (wr_q)
    begin
      case (addr_q)
        OFF_CTRL: ctrl_d = hwdata;
        OFF_ALIGN: align_d = hwdata;
        OFF_CAPS: caps_d = hwdata;
        OFF_OPEN: open_d = hwdata;
        OFF_ACCEL: accel_d = hwdata;
        OFF_HAND: hand_d = hwdata;
        OFF_SENSE: sense_d = hwdata;
        default: ;
      endcase
    end
    ctrl_d.rsv = '0;
    caps_d.rsv = '0;
    open_d.rsv = '0;
    hand_d.rsv = '0;
    sense_d.rsv = '0;
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ctrl_q <= CTRL_RST;
      align_q <= ALIGN_RST;
      caps_q <= CAPS_RST;
      open_q <= OPEN_RST;
      accel_q <= ACCEL_RST;
      hand_q <= HAND_RST;
      sense_q <= SENSE_RST;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (clk_en)
    begin
      ctrl_q <= ctrl_d;
      align_q <= align_d;
      caps_q <= caps_d;
      open_q <= open_d;
      accel_q <= accel_d;
      hand_q <= hand_d;
      sense_q <= sense_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      hrdata <= rdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [6:0] pre_q, pre_d;
  logic [15:0] tmr_q, tmr_d, min_t_q, min_t_d, tm_rdata;
  logic [7:0] ramp_q, ramp_d, duty_d, thr_d, cap_sel;
  logic [8:0] ramp_sum;
  logic [2:0] idx_q, idx_d, cyc_q, cyc_d;
  logic [SPEED_W-1:0] angle_q, angle_d, speed;
  logic [SPEED_W:0] angle_sum;
  logic slow_q, slow_d, second_q, second_d, lim_q, lim_d;
  logic tick, drv, acc_clear, acc_step, tm_we;
  bss_gate_t gate_d;
  // Both align and open loop share one cap source select
  assign cap_sel = ctrl_q.cap_src ? caps_q.ol_cap : caps_q.gen_cap;
  always_comb
  begin
    st_d = st_q;
    tmr_d = tmr_q;
    ramp_d = ramp_q;
    sec_d = sec_q;
    idx_d = idx_q;
    angle_d = angle_q;
    cyc_d = cyc_q;
    slow_d = slow_q;
    second_d = second_q;
    min_t_d = min_t_q;
    min_sec_d = min_sec_q;
    gate_d = '0;
    duty_d = 8'h00;
    thr_d = cap_sel;
    drv = 1'b0;
    acc_clear = 1'b0;
    acc_step = 1'b0;
    tm_we = 1'b0;
    tick = (pre_q == 7'(TICK_CYC - 1));
    pre_d = tick ? 7'h00 : pre_q + 7'h01;
    // Set wins over the clear of the same PWM edge
    lim_d = cur_at_thr | (lim_q & ~pwm_sync);
    ramp_sum = {1'b0, ramp_q} + {1'b0, align_q.ramp_step};
    angle_sum = {1'b0, angle_q} + {1'b0, speed};
    case (st_q)
      ST_IDLE:
      begin
        acc_clear = 1'b1;
        tmr_d = '0;
        ramp_d = '0;
        second_d = 1'b0;
        idx_d = '0;
        angle_d = '0;
        sec_d = 3'h0;
        if (start_req)
        begin
          case (ctrl_q.method)
            M_SENSE: st_d = ST_SDRIVE;
            M_SLOW:
            begin
              st_d = ST_OPEN;
              slow_d = 1'b1;
              cyc_d = '0;
            end
            default: st_d = ST_ALIGN;
          endcase
        end
      end
      ST_ALIGN:
      begin
        gate_d = pat(sec_q);
        duty_d = ramp_q;
        drv = 1'b1;
        if (tick)
        begin
          ramp_d = (ramp_sum >= {1'b0, align_q.duty}) ? align_q.duty :
            ramp_sum[7:0];
          tmr_d = tmr_q + 16'h0001;
          if (tmr_d >= align_q.time_ticks)
          begin
            tmr_d = '0;
            ramp_d = '0;
            if (ctrl_q.method == M_DOUBLE && !second_q)
            begin
              second_d = 1'b1;
              sec_d = sec_step(sec_q, 2'h1, ctrl_q.dir_rev);
            end
            else
            begin
              st_d = ST_OPEN;
              slow_d = 1'b0;
              sec_d = sec_step(sec_q, 2'h1, ctrl_q.dir_rev);
            end
          end
        end
      end
      ST_SDRIVE:
      begin
        gate_d = pat(sense_sec(idx_q));
        duty_d = 8'hFF;
        thr_d = caps_q.sense_thr;
        tmr_d = tmr_q + 16'h0001;
        if (cur_at_thr || tmr_d >= sense_q.limit)
        begin
          tm_we = 1'b1;
          st_d = ST_SREL;
        end
      end
      ST_SREL:
      begin
        // Recirculating keeps VM quiet but decays slower
        if (!ctrl_q.release_sel)
          gate_d.lo = pat(sense_sec(idx_q)).lo;
        thr_d = caps_q.sense_thr;
        tmr_d = tmr_q + 16'h0001;
        if (tmr_d >= sense_q.limit)
        begin
          tmr_d = '0;
          idx_d = idx_q + 3'h1;
          st_d = ST_SDRIVE;
          if (idx_q == SEC_LAST)
          begin
            idx_d = '0;
            st_d = ST_PICK;
          end
        end
      end
      ST_PICK:
      begin
        idx_d = idx_q + 3'h1;
        if (idx_q != 3'h0 && (idx_q == 3'h1 || tm_rdata < min_t_q))
        begin
          min_t_d = tm_rdata;
          min_sec_d = sense_sec(idx_q - 3'h1);
        end
        if (idx_q == 3'h6)
        begin
          st_d = ST_OPEN;
          slow_d = 1'b0;
          sec_d = sec_step(min_sec_d, open_q.advance, ctrl_q.dir_rev);
        end
      end
      ST_OPEN:
      begin
        gate_d = pat(sec_q);
        duty_d = open_q.duty;
        drv = 1'b1;
        if (tick && slow_q)
        begin
          tmr_d = tmr_q + 16'h0001;
          if (tmr_d >= open_q.first_period)
          begin
            tmr_d = '0;
            sec_d = sec_step(sec_q, 2'h1, ctrl_q.dir_rev);
            cyc_d = cyc_q + 3'h1;
            if (cyc_q == SEC_LAST)
              slow_d = 1'b0;
          end
        end
        else if (tick)
        begin
          acc_step = 1'b1;
          angle_d = angle_sum[SPEED_W-1:0];
          if (angle_sum[SPEED_W])
            sec_d = sec_step(sec_q, 2'h1, ctrl_q.dir_rev);
        end
        // Direction does not alter handover, accel or cap settings
        if (!slow_q && (ctrl_q.auto_hand ?
            (zero_cross && speed >= AUTO_SPEED) :
            (speed[SPEED_W-1 -: 16] >= hand_q.limit)))
          st_d = ST_CLOSED;
      end
      ST_CLOSED:
      begin
        gate_d = pat(sec_q);
        duty_d = duty_out;
        thr_d = caps_q.gen_cap;
        drv = 1'b1;
        if (zero_cross)
          sec_d = sec_step(sec_q, 2'h1, ctrl_q.dir_rev);
      end
      default: st_d = ST_IDLE;
    endcase
    if (drv && lim_q)
      gate_d.hi = 3'b000;
    if (ctrl_q.halt)
      st_d = ST_IDLE;
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_q <= ST_IDLE;
      pre_q <= 7'h00;
      tmr_q <= 16'h0000;
      ramp_q <= 8'h00;
      sec_q <= 3'h0;
      idx_q <= 3'h0;
      angle_q <= '0;
      cyc_q <= 3'h0;
      slow_q <= 1'b0;
      second_q <= 1'b0;
      min_t_q <= 16'h0000;
      min_sec_q <= 3'h0;
      lim_q <= 1'b0;
      gate_q <= '0;
      duty_q <= 8'h00;
      cur_thr_q <= 8'h00;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      pre_q <= pre_d;
      tmr_q <= tmr_d;
      ramp_q <= ramp_d;
      sec_q <= sec_d;
      idx_q <= idx_d;
      angle_q <= angle_d;
      cyc_q <= cyc_d;
      slow_q <= slow_d;
      second_q <= second_d;
      min_t_q <= min_t_d;
      min_sec_q <= min_sec_d;
      lim_q <= lim_d;
      gate_q <= gate_d;
      duty_q <= duty_d;
      cur_thr_q <= thr_d;
    end
  end
  bss_accel #(.W(SPEED_W)) bss_accel_inst (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .clear(acc_clear),
    .step(acc_step),
    .a1(accel_q.a1),
    .a2(accel_q.a2),
    .speed_q(speed)
  );
  bss_tmem #(.W(16), .D(6)) bss_tmem_inst (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .we(tm_we),
    .waddr(idx_q),
    .wdata(tmr_q),
    .raddr(idx_q),
    .rdata_q(tm_rdata)
  );
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_align_first: assert property (clk_en && st_q == ST_ALIGN &&
      !second_q && !lim_q |=> gate_q == '{3'b100, 3'b010})
    else $error("first align pattern wrong");
  a_ramp_bound: assert property (clk_en && st_q == ST_ALIGN &&
      st_d == ST_ALIGN && second_d == second_q |=>
      ramp_q >= $past(ramp_q) && ramp_q <= $past(align_q.duty))
    else $error("align duty not ramping");
  a_cap_source: assert property (clk_en &&
      (st_q == ST_ALIGN || st_q == ST_OPEN) |=> cur_thr_q == $past(cap_sel))
    else $error("current cap source wrong");
  a_second_shift: assert property (clk_en && st_q == ST_ALIGN &&
      !second_q && second_d |=>
      sec_q == sec_step($past(sec_q), 2'h1, $past(ctrl_q.dir_rev)))
    else $error("second align not one sector ahead");
  a_sense_stop: assert property (clk_en && st_q == ST_SDRIVE &&
      cur_at_thr && !ctrl_q.halt |=> st_q == ST_SREL)
    else $error("sense pulse not stopped");
  a_release_rec: assert property (clk_en && st_q == ST_SREL &&
      !ctrl_q.release_sel |=> gate_q.hi == 3'b000 && gate_q.lo != 3'b000)
    else $error("recirculate release wrong");
  a_release_hiz: assert property (clk_en && st_q == ST_SREL &&
      ctrl_q.release_sel |=> gate_q == '0)
    else $error("hi-z release not all off");
  a_open_duty: assert property (clk_en && st_q == ST_OPEN |=>
      duty_q == $past(open_q.duty))
    else $error("open-loop duty wrong");
  a_zc_commute: assert property (clk_en && st_q == ST_CLOSED &&
      zero_cross && !ctrl_q.halt |=>
      sec_q == sec_step($past(sec_q), 2'h1, $past(ctrl_q.dir_rev)))
    else $error("no commutation on zero crossing");
  a_closed_duty: assert property (clk_en && st_q == ST_CLOSED |=>
      duty_q == $past(duty_out))
    else $error("closed-loop duty wrong");
  a_start_taken: assert property (clk_en && st_q == ST_IDLE &&
      start_req && !ctrl_q.halt |=> st_q != ST_IDLE)
    else $error("start request ignored");
  c_double_align: cover property (st_q == ST_ALIGN && second_q);
  c_sense_pick: cover property (st_q == ST_PICK ##1 st_q == ST_OPEN);
  c_handover: cover property (st_q == ST_OPEN ##1 st_q == ST_CLOSED);
endmodule // bss_top
`default_nettype wire

// ---- dv/bss_motor.sv ----
// Behavioural winding model behind the half-bridges
`default_nettype none
module bss_motor (
  input wire logic core_clk, // Clock
  input wire bss_pkg::bss_gate_t gate_q, // Switch commands
  output logic cur_at_thr, // Current at threshold
  output logic pwm_sync, // PWM period start
  output logic zero_cross // Back-EMF crossing pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  import bss_pkg::*;
  int cnt = 0;
  int per = 0;
  logic drv;
  assign drv = (|gate_q.hi & |gate_q.lo) === 1'b1;
  // Pattern BA has the lowest inductance, so it rises fastest
  assign cur_at_thr = drv &&
    cnt >= ({gate_q.hi, gate_q.lo} == 6'h11 ? 5 : 12);
  assign pwm_sync = per % 50 == 0;
  assign zero_cross = per % 40 == 7;
  always @(posedge core_clk)
  begin
    cnt <= drv ? cnt + 1 : 0;
    per <= per + 1;
  end
endmodule // bss_motor
`default_nettype wire

// ---- dv/bss_top_tb_top.sv ----
// Self-checking bench for the start-up sequencer
`default_nettype none
module bss_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bss_pkg::*;
  logic core_clk = 0, reset = 1, hsel = 0, hwrite = 0, start_req = 0;
  logic hready, hreadyout, hresp, cur_at_thr, pwm_sync, zero_cross;
  logic ina = 0, jump = 0, seen = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [7:0] duty_out = 0, duty_q, cur_thr_q, prev = 0, pk = 0;
  logic [5:0] g, q[$];
  logic [5:0] pat [6] = '{6'h14, 6'h22, 6'h11, 6'h21, 6'h0C, 6'h0A};
  bss_gate_t gate_q;
  int err_count = 0, compares = 0, cyc = 0;
  assign hready = hreadyout;
  assign g = {gate_q.hi, gate_q.lo};
  bss_top bss_top_inst (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .start_req(start_req), .cur_at_thr(cur_at_thr), .pwm_sync(pwm_sync),
    .zero_cross(zero_cross), .duty_out(duty_out), .gate_q(gate_q),
    .duty_q(duty_q), .cur_thr_q(cur_thr_q));
  bss_motor bss_motor_inst (.core_clk(core_clk), .gate_q(gate_q),
    .cur_at_thr(cur_at_thr), .pwm_sync(pwm_sync), .zero_cross(zero_cross));
  // ----
  // Tasks
  // ----
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(0, 32'(hresp), "hresp");
  endtask
  task chk(input logic [31:0] e, input logic [31:0] s, input string nm);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wst(input logic [7:0] code);
    xfer(0, OFF_STATUS, 0);
    for (int i = 0; i < 5000 && rd[15:8] !== code; i++)
      xfer(0, OFF_STATUS, 0);
    chk(32'(code), 32'(rd[15:8]), "state");
  endtask
  task waitg(input logic [5:0] e);
    for (int i = 0; i < 3000 && g !== e; i++)
      @(posedge core_clk);
    chk(32'(e), 32'(g), "gate");
  endtask
  task go(input logic [31:0] ctrl);
    xfer(1, OFF_CTRL, 32'h0000_0040);
    xfer(1, OFF_CTRL, ctrl);
    start_req <= 1;
    @(posedge core_clk);
    start_req <= 0;
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // Monitor and timeout
  // ----
  always @(posedge core_clk)
  begin
    cyc++;
    // Open-loop duty ends the align ramp watch
    if (duty_q == 8'h40)
      ina = 0;
    if (ina && duty_q > prev + 9'd4)
      jump = 1;
    if (ina && duty_q > pk)
      pk = duty_q;
    // First cycle after a sensing pulse shows the release form
    if (prev == 8'hFF && gate_q.hi == 0 && gate_q.lo != 0)
      seen = 1;
    prev = duty_q;
    if (duty_q == 8'hFF && gate_q.hi != 0 && (q.size() == 0 || q[$] != g))
      q.push_back(g);
    if (cyc == 40000)
    begin
      err_count++;
      results();
    end
  end
  initial forever #5 core_clk = ~core_clk;
  initial
  begin
    repeat (6) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    xfer(0, OFF_ALIGN, 0);
    chk(ALIGN_RST, rd, "align reset");
    xfer(0, OFF_CAPS, 0);
    chk(CAPS_RST, rd, "caps reset");
    xfer(0, 8'h40, 0);
    chk(0, rd, "unmapped");
    xfer(1, OFF_STATUS, 32'hFFFF_FFFF);
    wst(8'h01);
    xfer(1, OFF_ALIGN, 32'h0410_0008);
    xfer(1, OFF_CAPS, 32'h0040_2080);
    xfer(1, OFF_OPEN, 32'h0200_0240);
    xfer(1, OFF_SENSE, 32'h0000_0020);
    xfer(1, OFF_ACCEL, 32'h0001_0100);
    xfer(1, OFF_HAND, 32'h0000_0004);
    $display("registers done");
    ina = 1;
    go(0);
    waitg(6'h22);
    chk(32'h80, 32'(cur_thr_q), "align cap");
    wst(8'h20);
    ina = 0;
    chk(1, 32'(rd[2:0]), "open sector");
    chk(32'h40, 32'(duty_q), "open duty");
    chk(32'h80, 32'(cur_thr_q), "open cap");
    chk(32'h10, 32'(pk), "align peak");
    chk(0, 32'(jump), "align step");
    duty_out <= 8'h5A;
    wst(8'h40);
    @(posedge core_clk);
    chk(32'h5A, 32'(duty_q), "closed duty");
    $display("single align done");
    go(32'h0000_0011);
    waitg(6'h22);
    waitg(6'h0A);
    wst(8'h20);
    chk(2, 32'(rd[2:0]), "double sector");
    repeat (1000) @(posedge core_clk);
    xfer(0, OFF_STATUS, 0);
    chk(32'h20, 32'(rd[15:8]), "auto hold");
    wst(8'h40);
    $display("double align done");
    go(32'h0000_0023);
    wst(8'h20);
    chk(0, 32'(rd[2:0]), "slow start");
    repeat (900) @(posedge core_clk);
    xfer(0, OFF_STATUS, 0);
    chk(32'h20, 32'(rd[15:8]), "slow hold");
    wst(8'h40);
    $display("slow first cycle done");
    for (int rel = 0; rel < 2; rel++)
    begin
      q.delete();
      seen = 0;
      go({28'h0, rel[0], 3'h6});
      wst(8'h20);
      chk(4, 32'(rd[5:3]), "detected");
      chk(0, 32'(rd[2:0]), "start sector");
      chk(32'h20, 32'(cur_thr_q), "sense open cap");
      chk(32'(!rel[0]), 32'(seen), "recirculate");
      chk(6, q.size(), "patterns");
      for (int i = 0; i < 6; i++)
        chk(32'(pat[i]), 32'(q[i]), "pattern");
      $display("sensing done");
    end
    results();
  end
endmodule // bss_top_tb_top
`default_nettype wire
